// >>> clk_sel_chk_asserts.sv
// assertions for the pwm and system clock select block
`timescale 1ns/100ps
`default_nettype none
module clk_sel_chk (
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        pll_power_down,
    input wire logic        sys_clk_sel_pll,
    input wire logic [3:0]  system_clock_divisor,
    input wire logic        pwm_clk_tick
);
    logic       wr;
    logic       pen;
    logic [2:0] sel;
    logic [7:0] calm;
    logic [6:0] gap;
    assign wr = psel && penable && pwrite && paddr == 12'h060;
    // shadow of the pwm fields; calm skips the one short period after a change
    always @(posedge sys_clk) begin
        pen <= srst ? 1'b0 : (wr ? pwdata[20] : pen);
        sel <= srst ? 3'h7 : (wr ? pwdata[19:17] : sel);
        calm <= (srst || wr) ? 8'h0 : calm + {7'h0, calm != 8'hFF};
        gap <= (srst || pwm_clk_tick) ? 7'h0 : gap + 7'h1;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    sequence wr_s;
        wr;
    endsequence
    ready_access_a: assert property (psel && penable |-> pready)
        else $error("access without ready");
    slverr_map_a: assert property (pslverr == (psel && penable && paddr != 12'h060))
        else $error("slave error mismatch");
    rsv_read_a: assert property (psel && penable && !pwrite && !pslverr |->
        prdata[16:14] == 3'h0 && prdata[12] && !prdata[10]) else $error("reserved bits");
    pll_pd_a: assert property (wr_s |=> pll_power_down == $past(pwdata[13]))
        else $error("power-down not following bit");
    bypass_sel_a: assert property (wr_s |=> ##1 sys_clk_sel_pll == !$past(pwdata[11], 2))
        else $error("source select wrong");
    sys_div_a: assert property (wr_s |=> ##1 system_clock_divisor == $past(pwdata[26:23], 2))
        else $error("system divisor wrong");
    pwm_off_a: assert property (!pen && calm > 8'h2 |-> pwm_clk_tick)
        else $error("pwm clock not undivided");
    pwm_period_a: assert property (pen && calm > 8'h82 && pwm_clk_tick |->
        gap == (sel > 3'h4 ? 7'h3F : (7'h2 << sel) - 7'h1)) else $error("pwm period wrong");
endmodule // clk_sel_chk
`default_nettype wire

// >>> clk_sel_consts.vh
// constants for the pwm and system clock select block
`ifndef CLK_SEL_CONSTS_VH
`define CLK_SEL_CONSTS_VH

// ----------------------------------------
// register map
// ----------------------------------------
`define RMCC_ADDR          12'h060
`define RMCC_RESET         32'h078E3AD1

// ----------------------------------------
// field positions
// ----------------------------------------
`define SYSTEM_CLOCK_DIVISOR_MSB         26
`define SYSTEM_CLOCK_DIVISOR_LSB         23
`define SYSTEM_CLOCK_DIVISOR_USE_BIT     22
`define PWM_DIVISOR_SELECT_EN_BIT      20
`define PWM_DIVISOR_SELECT_MSB         19
`define PWM_DIVISOR_SELECT_LSB         17
`define PLL_PD_BIT         13
`define RSV_ONE_BIT        12
`define BYPASS_BIT         11
`define OSCILLATOR_SOURCE_SELECT_MSB         5
`define OSCILLATOR_SOURCE_SELECT_LSB         4

// ----------------------------------------
// field values
// ----------------------------------------
`define PWM_DIVISOR_SELECT_RESET       3'h7
`define PWM_DIVISOR_SELECT_MAX_SEL     3'h5
`define SYSTEM_CLOCK_DIVISOR_RESET       4'hF
`define OSCILLATOR_SOURCE_SELECT_MAIN        2'h0
`define OSCILLATOR_SOURCE_SELECT_RING        2'h1
`define OSCILLATOR_SOURCE_SELECT_RING_DIV4   2'h2
`define RING_DIV4_LAST     2'h3

`endif

// >>> pwm_and_system_clock_select.v
// pwm predivider, pll power-down and system clock source selection
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "clk_sel_consts.vh"

// Functional notes
// - with the pwm predivider enable set, the pwm clock comes from the predivider output.
// - divisor select 0..4 divides by 2,4,8,16,32 and 5..7 by 64, reset 7.
// - the pwm clock uses power-of-two ratios and rises only on a system clock rising edge.
// - the pll power-down bit drives the pll power-down input directly and resets to 1.
// - with bypass set the system clock comes from the selected oscillator source.
// - with bypass clear the system clock is the pll output divided by the system divisor plus one.
// - bits 16:14 and 10 read 0, bit 12 reads 1, and writes to them are ignored.
// - the 4-bit system clock divisor, reset 0xF, selects the divide from pll or oscillator.
// - when the pll is the source the system divider is always applied.
// - oscillator source 0 is the main crystal, 1 the ring (reset), 2 the ring divided by 4.
module pwm_and_system_clock_select (
    input  wire        sys_clk,
    input  wire        srst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    input  wire        main_crystal_clock,
    input  wire        internal_ring_clock,
    input  wire        pll_out_clock,
    output wire        pll_power_down,
    output reg         sys_clk_sel_pll,
    output reg  [1:0]  oscillator_source_select,
    output reg         osc_source_tick,
    output reg  [3:0]  system_clock_divisor,
    output reg         sys_div_tick,
    output reg         pwm_clk_tick
);

// ----------------------------------------
// register fields
// ----------------------------------------
reg        pwm_predivider_enable;
reg  [2:0] pwm_divisor_select;
reg        pll_pd;
reg        bypass;
reg        system_divider_use;
reg  [3:0] system_clock_divisor_q;
reg  [1:0] osc_q;
reg  [5:0] pwm_cnt;
reg  [3:0] sys_cnt;
reg  [1:0] ring_cnt;
reg  [31:0] rd_word;
reg  [31:0] pwm_mask;
reg        div_active;
reg        osc_raw;
reg        src_tick;

// ----------------------------------------
// apb decode
// ----------------------------------------
wire       hit;
wire       wr_take;
wire       rd_setup;
assign hit      = (paddr == `RMCC_ADDR);
assign wr_take  = psel & penable & pwrite & hit;
assign rd_setup = psel & ~penable & ~pwrite & hit;

// zero-wait slave, unmapped addresses answer with an error
assign pready  = 1'b1;
assign pslverr = psel & penable & ~hit;
assign pll_power_down = pll_pd;

// ----------------------------------------
// mask for the power-of-two divide
// ----------------------------------------
function [31:0] pwm_mask_of;
    input [2:0] sel;
    begin
        if (sel >= `PWM_DIVISOR_SELECT_MAX_SEL) begin
            pwm_mask_of = 32'h0000003F;
        end else begin
            pwm_mask_of = (32'h00000002 << sel) - 32'h00000001;
        end
    end
endfunction

// ----------------------------------------
// control fields, one flop group per field
// ----------------------------------------
// reserved bits have no storage, so writes to them vanish
always @(posedge sys_clk) begin
    if (srst) begin
        pwm_predivider_enable <= 1'b0;
    end else if (wr_take) begin
        pwm_predivider_enable <= pwdata[`PWM_DIVISOR_SELECT_EN_BIT];
    end
end

always @(posedge sys_clk) begin
    if (srst) begin
        pwm_divisor_select <= `PWM_DIVISOR_SELECT_RESET;
    end else if (wr_take) begin
        pwm_divisor_select <= pwdata[`PWM_DIVISOR_SELECT_MSB:`PWM_DIVISOR_SELECT_LSB];
    end
end

// pll stays powered down until software clears it
always @(posedge sys_clk) begin
    if (srst) begin
        pll_pd <= 1'b1;
    end else if (wr_take) begin
        pll_pd <= pwdata[`PLL_PD_BIT];
    end
end

// the oscillator drives the system out of reset
always @(posedge sys_clk) begin
    if (srst) begin
        bypass <= 1'b1;
    end else if (wr_take) begin
        bypass <= pwdata[`BYPASS_BIT];
    end
end

always @(posedge sys_clk) begin
    if (srst) begin
        system_divider_use <= 1'b0;
    end else if (wr_take) begin
        system_divider_use <= pwdata[`SYSTEM_CLOCK_DIVISOR_USE_BIT];
    end
end

always @(posedge sys_clk) begin
    if (srst) begin
        system_clock_divisor_q <= `SYSTEM_CLOCK_DIVISOR_RESET;
    end else if (wr_take) begin
        system_clock_divisor_q <= pwdata[`SYSTEM_CLOCK_DIVISOR_MSB:`SYSTEM_CLOCK_DIVISOR_LSB];
    end
end

always @(posedge sys_clk) begin
    if (srst) begin
        osc_q <= `OSCILLATOR_SOURCE_SELECT_RING;
    end else if (wr_take) begin
        osc_q <= pwdata[`OSCILLATOR_SOURCE_SELECT_MSB:`OSCILLATOR_SOURCE_SELECT_LSB];
    end
end

// ----------------------------------------
// read path
// ----------------------------------------
always @* begin
    // unimplemented fields read as zero, apart from bit 12
    rd_word = 32'h00000000;
    rd_word[`SYSTEM_CLOCK_DIVISOR_MSB:`SYSTEM_CLOCK_DIVISOR_LSB] = system_clock_divisor_q;
    rd_word[`SYSTEM_CLOCK_DIVISOR_USE_BIT]         = system_divider_use;
    rd_word[`PWM_DIVISOR_SELECT_EN_BIT]          = pwm_predivider_enable;
    rd_word[`PWM_DIVISOR_SELECT_MSB:`PWM_DIVISOR_SELECT_LSB] = pwm_divisor_select;
    rd_word[`PLL_PD_BIT]             = pll_pd;
    rd_word[`RSV_ONE_BIT]            = 1'b1;
    rd_word[`BYPASS_BIT]             = bypass;
    rd_word[`OSCILLATOR_SOURCE_SELECT_MSB:`OSCILLATOR_SOURCE_SELECT_LSB] = osc_q;
end

always @(posedge sys_clk) begin
    if (srst) begin
        prdata <= 32'h00000000;
    end else if (rd_setup) begin
        prdata <= rd_word;
    end else if (psel & ~penable) begin
        prdata <= 32'h00000000;
    end
end

// ----------------------------------------
// pwm predivider
// ----------------------------------------
always @* begin
    pwm_mask = pwm_mask_of(pwm_divisor_select);
end

// free counter, so every tick lands on a system clock edge
// a divisor change may give one short period, the counter is cleared only by reset
always @(posedge sys_clk) begin
    if (srst) begin
        pwm_cnt <= 6'h00;
    end else begin
        pwm_cnt <= pwm_cnt + 6'h01;
    end
end

always @(posedge sys_clk) begin
    if (srst) begin
        pwm_clk_tick <= 1'b0;
    end else if (pwm_predivider_enable) begin
        pwm_clk_tick <= ((pwm_cnt & pwm_mask[5:0]) == pwm_mask[5:0]);
    end else begin
        pwm_clk_tick <= 1'b1;
    end
end

// ----------------------------------------
// system clock source and divider
// ----------------------------------------
always @* begin
    // the pll path always divides, the divider-use bit only matters in bypass
    div_active = ~bypass | system_divider_use;
end

// counts ring ticks, not system clocks, so the quarter rate holds
always @(posedge sys_clk) begin
    if (srst) begin
        ring_cnt <= 2'h0;
    end else if (internal_ring_clock) begin
        ring_cnt <= ring_cnt + 2'h1;
    end
end

always @* begin
    case (osc_q)
        `OSCILLATOR_SOURCE_SELECT_MAIN: begin
            osc_raw = main_crystal_clock;
        end
        `OSCILLATOR_SOURCE_SELECT_RING: begin
            osc_raw = internal_ring_clock;
        end
        `OSCILLATOR_SOURCE_SELECT_RING_DIV4: begin
            // one ring tick in four
            osc_raw = internal_ring_clock & (ring_cnt == `RING_DIV4_LAST);
        end
        default: begin
            // code 3 is unused and falls back to the plain ring
            osc_raw = internal_ring_clock;
        end
    endcase
end

// sources are treated as tick enables sampled on sys_clk
always @(posedge sys_clk) begin
    if (srst) begin
        sys_clk_sel_pll <= 1'b0;
    end else begin
        sys_clk_sel_pll <= ~bypass;
    end
end

always @(posedge sys_clk) begin
    if (srst) begin
        oscillator_source_select <= `OSCILLATOR_SOURCE_SELECT_RING;
    end else begin
        oscillator_source_select <= osc_q;
    end
end

always @(posedge sys_clk) begin
    if (srst) begin
        system_clock_divisor <= `SYSTEM_CLOCK_DIVISOR_RESET;
    end else begin
        system_clock_divisor <= system_clock_divisor_q;
    end
end

always @(posedge sys_clk) begin
    if (srst) begin
        osc_source_tick <= 1'b0;
    end else begin
        osc_source_tick <= osc_raw;
    end
end

// ----------------------------------------
// system divider
// ----------------------------------------
always @* begin
    if (bypass) begin
        src_tick = osc_raw;
    end else begin
        src_tick = pll_out_clock;
    end
end

always @(posedge sys_clk) begin
    if (srst) begin
        sys_cnt      <= 4'h0;
        sys_div_tick <= 1'b0;
    end else if (src_tick) begin
        if (!div_active || sys_cnt >= system_clock_divisor_q) begin
            sys_cnt      <= 4'h0;
            sys_div_tick <= 1'b1;
        end else begin
            sys_cnt      <= sys_cnt + 4'h1;
            sys_div_tick <= 1'b0;
        end
    end else begin
        sys_div_tick <= 1'b0;
    end
end

endmodule // pwm_and_system_clock_select
`default_nettype wire

// >>> tb_pwm_and_system_clock_select.sv
// self-checking bench for the pwm and system clock select block
`timescale 1ns/100ps
`default_nettype none
`include "clk_sel_consts.vh"
module tb_pwm_and_system_clock_select;
    logic        sys_clk, srst, psel, penable, pwrite, pready, pslverr, pll_power_down, err;
    logic        sys_clk_sel_pll, osc_source_tick, sys_div_tick, pwm_clk_tick;
    logic [1:0]  oscillator_source_select;
    logic [3:0]  system_clock_divisor;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] cyc = 16'h0;
    logic [31:0] na, nb;
    int          bad_count, n_checks, p, i;
    // source ticks come from a free counter: the ring ticks one cycle in four, the crystal and the pll each on half the cycles
    pwm_and_system_clock_select uut (.sys_clk, .srst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr, .main_crystal_clock(cyc[0]),
        .internal_ring_clock(cyc[1:0] == 2'h0), .pll_out_clock(cyc[2]), .pll_power_down,
        .sys_clk_sel_pll, .oscillator_source_select, .osc_source_tick,
        .system_clock_divisor, .sys_div_tick, .pwm_clk_tick);
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc <= cyc + 16'h1;
        if (cyc == 16'h4E20) begin
            bad_count++;
            print_verdict;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // gap between the second and third ticks seen, so a short period after a change is skipped
    task period;
        repeat (3) begin
            p = 0;
            do begin
                @(posedge sys_clk);
                p++;
            end while (pwm_clk_tick !== 1'b1 && p < 200);
        end
    endtask
    // counts both tick outputs over a window that every source period divides
    task src_test(input logic [31:0] w, input logic [31:0] n_osc, input logic [31:0] n_div);
        apb(1'b1, `RMCC_ADDR, w);
        repeat (16) @(posedge sys_clk);
        na = 32'h0;
        nb = 32'h0;
        repeat (64) begin
            @(posedge sys_clk);
            na += osc_source_tick;
            nb += sys_div_tick;
        end
        chk(na, n_osc);
        chk(nb, n_div);
        chk(oscillator_source_select, w[5:4]);
    endtask
    task print_verdict;
        $display("checks=%0d bad=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, srst} = {3'h0, 12'h0, 32'h0, 1'b1};
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        apb(1'b0, `RMCC_ADDR, 32'h0);
        chk(rd, 32'h078E3810);
        chk({err, pll_power_down, sys_clk_sel_pll}, 32'h2);
        apb(1'b1, `RMCC_ADDR, 32'hFFFFFFFF);
        apb(1'b0, `RMCC_ADDR, 32'h0);
        chk(rd, 32'h07DE3830);
        apb(1'b1, `RMCC_ADDR, 32'h0);
        apb(1'b0, `RMCC_ADDR, 32'h0);
        chk(rd, 32'h00001000);
        chk({pll_power_down, sys_clk_sel_pll, system_clock_divisor}, 32'h10);
        $display("register test done");
        for (i = 0; i < 8; i++) begin
            apb(1'b1, `RMCC_ADDR, 32'h00100000 | (32'(i) << 17));
            period;
            chk(p, 2 << (i > 5 ? 5 : i));
        end
        apb(1'b1, `RMCC_ADDR, 32'h0);
        period;
        chk(p, 32'h1);
        $display("pwm test done");
        src_test(32'h00000800, 32'd32, 32'd32);
        src_test(32'h00000810, 32'd16, 32'd16);
        src_test(32'h00000820, 32'd4, 32'd4);
        src_test(32'h00C00800, 32'd32, 32'd16);
        src_test(32'h01800000, 32'd32, 32'd8);
        $display("source test done");
        apb(1'b0, 12'h064, 32'h0);
        chk(rd, 32'h0);
        chk(err, 32'h1);
        apb(1'b1, 12'h064, 32'hFFFFFFFF);
        chk(err, 32'h1);
        apb(1'b0, `RMCC_ADDR, 32'h0);
        chk(rd, 32'h01801000);
        $display("address map test done");
        print_verdict;
    end
endmodule // tb_pwm_and_system_clock_select
bind pwm_and_system_clock_select clk_sel_chk chk_i (.sys_clk, .srst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .pll_power_down,
    .sys_clk_sel_pll, .system_clock_divisor, .pwm_clk_tick);
`default_nettype wire
